// ===== hdl/tsc_attach_ctrl.sv
// attach detection, power steering and thermal cycling of a type-c source port
//
// Operation
// - low cc level means attached termination
// - both open: power off, flags released
// - rd on cc1: vbus on, sink flag
// - rd on cc2: vbus, sink, flip flag
// - lone ra: power off, flags released
// - rd plus ra: vbus, vconn on ra
// - rd on both: debug flag only
// - ra on both: audio flag only
// - flags open-drain, never driven high
// - two selects choose advertised current
// - limit and sense threshold ignore selects
// - hot in current limit turns switch off
// - cool by hysteresis, then restart
// - enable low: all off, monitor stopped
// - audio detach watched on cc2
// - debug detach watched on cc1
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/100ps
module tsc_attach_ctrl
   import tsc_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DEF          // cycles per deglitch tick
) (
   input  wire logic              i_ref_clk,            // 50 mhz reference clock
   input  wire logic              i_reset_n,            // synchronous reset
   // apb slave
   input  wire logic              i_psel,               // slave select
   input  wire logic              i_penable,            // access phase
   input  wire logic              i_pwrite,             // write access
   input  wire logic [ADDR_W-1:0] i_paddr,              // byte address
   input  wire logic [31:0]       i_pwdata,             // write data
   output logic      [31:0]       o_prdata,             // read data
   output logic                   o_pready,             // transfer done
   output logic                   o_pslverr,            // unmapped address
   // pins
   input  wire logic              i_enable,             // device enable
   input  wire logic              i_cc1_below_open,     // cc1 under open level
   input  wire logic              i_cc1_below_ra,       // cc1 under rd/ra boundary
   input  wire logic              i_cc2_below_open,     // cc2 under open level
   input  wire logic              i_cc2_below_ra,       // cc2 under rd/ra boundary
   input  wire logic              i_charge_select_hi_level,  // type-c current select
   input  wire logic              i_charge_select_high_amp,  // 3 a select
   input  wire logic              i_in_current_limit,   // switch is regulating current
   input  wire logic              i_over_temp,          // junction above limit threshold
   input  wire logic              i_temp_cooled,        // junction cooled by hysteresis
   input  wire logic              i_load_above_cs,      // load above sense threshold
   input  wire logic [N_FLAG-1:0] i_flag_pin,           // open-drain pin levels
   output logic      [N_FLAG-1:0] o_flag_out,           // open-drain data, always low
   output logic      [N_FLAG-1:0] o_flag_oe,            // pull pin low when high
   output logic                   o_vbus_switch_en,     // vbus_supply_input to vbus
   output logic                   o_vconn_cc1_en,       // vconn onto cc1
   output logic                   o_vconn_cc2_en,       // vconn onto cc2
   output logic      [1:0]        o_adv_level,          // advertised current code
   output logic                   o_irq                 // level interrupt
);
   // every flip-flop of the block outside the deglitch filters
   typedef struct packed {
      logic [N_SY-1:0]   sy1;        // first synchroniser stage
      logic [N_SY-1:0]   sy2;        // second synchroniser stage
      tsc_therm_t        therm;      // overtemperature cycle state
      logic              ctrl_en;    // software enable
      logic [N_IRQ-1:0]  irq_stat;   // sticky events
      logic [N_IRQ-1:0]  irq_mask;   // event enables
      logic [N_DEB-1:0]  deb_q;      // deglitched flags, last cycle
      logic [TICK_W-1:0] tick_cnt;   // tick divider
      logic              tick;       // one-cycle tick enable
      logic              pready;     // apb answer
      logic              pslverr;    // apb error
      logic [31:0]       prdata;     // apb read data
      logic              vbus;       // vbus switch
      logic              vconn1;     // vconn to cc1
      logic              vconn2;     // vconn to cc2
      logic [1:0]        adv;        // advertised current
      logic [N_FLAG-1:0] flag_out;   // open-drain data
      logic [N_FLAG-1:0] flag_oe;    // open-drain enables
      logic              irq;        // interrupt output
   } tsc_state_t;

   tsc_state_t        st;            // registered state
   tsc_state_t        next_st;       // next state
   logic [N_SY-1:0]   raw_pins;      // pins before synchronising
   logic [N_DEB-1:0]  deb_raw;       // flag conditions before deglitch
   logic [N_DEB-1:0]  deb;           // deglitched flag conditions
   tsc_cc_t           cls1;          // cc1 termination class
   tsc_cc_t           cls2;          // cc2 termination class
   logic              run;           // device enabled by pin and software
   logic              pwr_ok;        // switches allowed by thermal state
   logic              sink_ok;       // sink attached, no accessory
   logic              access;        // apb access phase
   logic              wr_done;       // write completes this edge
   logic [N_IRQ-1:0]  irq_ev;        // events this cycle
   logic [N_IRQ-1:0]  irq_clr;       // write-one-to-clear bits
   logic [31:0]       rd_val;        // read mux
   logic              rd_hit;        // mapped address

   // deglitch times per flag position
   localparam logic [N_DEB-1:0][CNT_W-1:0] DEB_SET = {CS_SET_TICKS, {4{FLAG_SET_TICKS}}};
   localparam logic [N_DEB-1:0][CNT_W-1:0] DEB_CLR = {CS_CLR_TICKS, {4{FLAG_CLR_TICKS}}};

   // classify one cc line from its two comparators
   function automatic tsc_cc_t cc_class(input logic below_open, input logic below_ra);
      tsc_cc_t c;
      if (!below_open) begin
         c = CC_OPEN;
      end else if (below_ra) begin
         c = CC_RA;
      end else begin
         c = CC_RD;
      end
      return c;
   endfunction

   // advertised current from the two selects
   function automatic logic [1:0] adv_code(input logic lvl, input logic amp);
      logic [1:0] a;
      if (!lvl) begin
         a = ADV_DEFAULT;
      end else if (amp) begin
         a = ADV_3A;
      end else begin
         a = ADV_1A5;
      end
      return a;
   endfunction

   // all pins in synchroniser order
   assign raw_pins = {i_flag_pin, i_load_above_cs, i_temp_cooled, i_over_temp, i_in_current_limit,
                      i_charge_select_high_amp, i_charge_select_hi_level, i_enable,
                      i_cc2_below_ra, i_cc2_below_open, i_cc1_below_ra, i_cc1_below_open};

   // outputs straight from the state register
   assign o_prdata         = st.prdata;
   assign o_pready         = st.pready;
   assign o_pslverr        = st.pslverr;
   assign o_flag_out       = st.flag_out;
   assign o_flag_oe        = st.flag_oe;
   assign o_vbus_switch_en = st.vbus;
   assign o_vconn_cc1_en   = st.vconn1;
   assign o_vconn_cc2_en   = st.vconn2;
   assign o_adv_level      = st.adv;
   assign o_irq            = st.irq;

   // one deglitch filter for each of the five deglitched flags, cleared while disabled
   // a cleared filter restarts its full hold time on the next enable
   genvar g;
   generate
      for (g = 0; g < N_DEB; g = g + 1) begin : g_deb
         tsc_deglitch #(
            .SET_TICKS (DEB_SET[g]),
            .CLR_TICKS (DEB_CLR[g])
         ) u_deg (
            .i_ref_clk (i_ref_clk),
            .i_reset_n (i_reset_n),
            .i_tick    (st.tick),
            .i_clear   (!run),
            .i_raw     (deb_raw[g]),
            .o_level   (deb[g])
         );
      end
   endgenerate

   // line classes and raw flag conditions
   always_comb begin
      cls1 = cc_class(st.sy2[SY_CC1_OPEN], st.sy2[SY_CC1_RA]);
      cls2 = cc_class(st.sy2[SY_CC2_OPEN], st.sy2[SY_CC2_RA]);
      run  = st.sy2[SY_EN] && st.ctrl_en;
      deb_raw = '0;
      // one rd line: sink attached, other line open or ra
      if (!deb[FLG_AUDIO] && !deb[FLG_DEBUG]) begin
         deb_raw[FLG_SINK] = (cls1 == CC_RD) != (cls2 == CC_RD);
         deb_raw[FLG_FLIP] = (cls2 == CC_RD) && (cls1 != CC_RD);
      end
      // audio: enter on ra/ra, leave on cc2 alone
      if (deb[FLG_AUDIO]) begin
         deb_raw[FLG_AUDIO] = (cls2 == CC_RA);
      end else begin
         deb_raw[FLG_AUDIO] = (cls1 == CC_RA) && (cls2 == CC_RA) && !deb[FLG_DEBUG];
      end
      // debug: enter on rd/rd, leave on cc1 alone
      if (deb[FLG_DEBUG]) begin
         deb_raw[FLG_DEBUG] = (cls1 == CC_RD);
      end else begin
         deb_raw[FLG_DEBUG] = (cls1 == CC_RD) && (cls2 == CC_RD) && !deb[FLG_AUDIO];
      end
      // load sense threshold is the same for every select setting
      deb_raw[FLG_CS] = st.sy2[SY_CS] && st.vbus;
   end

   // next state
   always_comb begin
      next_st = st;
      // synchronisers
      // every pin passes two flops; nothing but the second stage reads the first
      next_st.sy1 = raw_pins;
      next_st.sy2 = st.sy1;
      // deglitch time base
      // one shared tick keeps the filter counters narrow
      next_st.tick = 1'b0;
      if (st.tick_cnt >= TICK_W'(TICK_CYCLES - 1)) begin
         next_st.tick_cnt = '0;
         next_st.tick     = 1'b1;
      end else begin
         next_st.tick_cnt = st.tick_cnt + 1'b1;
      end
      // thermal cycling while in current limit
      // the thermal state survives a disable, so a hot switch is not retried early
      case (st.therm)
         TH_RUN: begin
            if (run && st.sy2[SY_ILIM] && st.sy2[SY_HOT]) begin
               next_st.therm = TH_COOL;
            end
         end
         TH_COOL: begin
            if (st.sy2[SY_COOL]) begin
               next_st.therm = TH_RUN;
            end
         end
         default: begin
            next_st.therm = TH_RUN;
         end
      endcase
      pwr_ok  = run && (next_st.therm == TH_RUN);
      sink_ok = deb[FLG_SINK] && !deb[FLG_AUDIO] && !deb[FLG_DEBUG];
      // power switches follow the deglitched attach state
      // an accessory blocks power even while a sink pattern is still settling
      next_st.vbus   = pwr_ok && sink_ok;
      next_st.vconn1 = pwr_ok && sink_ok && (cls1 == CC_RA);
      next_st.vconn2 = pwr_ok && sink_ok && (cls2 == CC_RA);
      next_st.adv    = adv_code(st.sy2[SY_SEL_LVL], st.sy2[SY_SEL_AMP]);
      // open-drain flags only ever pull low
      next_st.flag_out            = '0;
      next_st.flag_oe[FLG_FLIP]   = run && sink_ok && deb[FLG_FLIP];
      next_st.flag_oe[FLG_SINK]   = run && sink_ok;
      next_st.flag_oe[FLG_AUDIO]  = run && deb[FLG_AUDIO];
      next_st.flag_oe[FLG_DEBUG]  = run && deb[FLG_DEBUG];
      next_st.flag_oe[FLG_CS]     = run && deb[FLG_CS];
      next_st.flag_oe[FLG_FAULT]  = run && (st.therm == TH_COOL);
      // events
      // sink edges, accessory entries and thermal shutdown become sticky interrupt events
      next_st.deb_q = deb;
      irq_ev = '0;
      irq_ev[IRQ_ATTACH] = deb[FLG_SINK] && !st.deb_q[FLG_SINK];
      irq_ev[IRQ_DETACH] = !deb[FLG_SINK] && st.deb_q[FLG_SINK];
      irq_ev[IRQ_ACCESS] = (deb[FLG_AUDIO] && !st.deb_q[FLG_AUDIO]) ||
                           (deb[FLG_DEBUG] && !st.deb_q[FLG_DEBUG]);
      irq_ev[IRQ_THERM]  = (st.therm == TH_RUN) && (next_st.therm == TH_COOL);
      // apb decode
      // decoded straight from the bus so read data can be registered with pready
      access  = i_psel && i_penable;
      wr_done = access && st.pready && i_pwrite && !st.pslverr;
      rd_hit  = 1'b1;
      case (i_paddr)
         REG_CTRL:     rd_val = {31'h0, st.ctrl_en};
         REG_STATUS:   rd_val = {19'h0, run, st.therm == TH_COOL, st.adv, cls2, cls1, deb};
         REG_IRQ_STAT: rd_val = {28'h0, st.irq_stat};
         REG_IRQ_MASK: rd_val = {28'h0, st.irq_mask};
         REG_PINS:     rd_val = {26'h0, st.sy2[SY_PIN +: N_FLAG]};
         default: begin
            rd_val = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
      // answer one cycle into the access phase
      next_st.pready = access && !st.pready;
      if (access && !st.pready) begin
         next_st.prdata  = i_pwrite ? 32'h0 : rd_val;
         next_st.pslverr = !rd_hit;
      end else begin
         next_st.pslverr = 1'b0;
      end
      // writes take effect on the completing edge
      irq_clr = '0;
      if (wr_done) begin
         case (i_paddr)
            REG_CTRL:     next_st.ctrl_en  = i_pwdata[0];
            REG_IRQ_STAT: irq_clr          = i_pwdata[N_IRQ-1:0];
            REG_IRQ_MASK: next_st.irq_mask = i_pwdata[N_IRQ-1:0];
            default:      next_st.ctrl_en  = st.ctrl_en;
         endcase
      end
      // a new event wins over a clear in the same cycle
      next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_ev;
      next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
   end

   // state register
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         st          <= '0;
         st.ctrl_en  <= CTRL_EN_RST;
         st.irq_mask <= IRQ_MASK_RST;
      end else begin
         st <= next_st;
      end
   end

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   open_idle_a: assert property ((cls1 == CC_OPEN) && (cls2 == CC_OPEN) && (deb == '0)
      |=> !o_vbus_switch_en && !o_vconn_cc1_en && !o_vconn_cc2_en && (o_flag_oe[3:0] == '0))
      else $error("open port not idle");
   ra_idle_a: assert property (((cls1 == CC_RA) != (cls2 == CC_RA)) && (cls1 != CC_RD) && (cls2 != CC_RD)
      && (deb == '0) |=> !o_vbus_switch_en && !o_vconn_cc1_en && !o_vconn_cc2_en)
      else $error("lone ra powered the port");
   sink_power_a: assert property (pwr_ok && sink_ok
      |=> o_vbus_switch_en && o_flag_oe[FLG_SINK] && (o_flag_oe[FLG_FLIP] == $past(deb[FLG_FLIP])))
      else $error("sink attach did not power vbus");
   vconn_steer_a: assert property (pwr_ok && sink_ok && (cls2 == CC_RA) && (cls1 == CC_RD)
      |=> o_vconn_cc2_en && !o_vconn_cc1_en)
      else $error("vconn not steered to ra line");
   debug_only_a: assert property (deb[FLG_DEBUG] && run
      |=> !o_vbus_switch_en && !o_vconn_cc1_en && !o_vconn_cc2_en && o_flag_oe[FLG_DEBUG])
      else $error("debug accessory mishandled");
   audio_only_a: assert property (deb[FLG_AUDIO] && run
      |=> !o_vbus_switch_en && !o_vconn_cc1_en && !o_vconn_cc2_en && o_flag_oe[FLG_AUDIO])
      else $error("audio accessory mishandled");
   never_high_a: assert property (o_flag_out == '0)
      else $error("open-drain flag driven high");
   adv_code_a: assert property (##1 o_adv_level == adv_code($past(st.sy2[SY_SEL_LVL]),
      $past(st.sy2[SY_SEL_AMP])))
      else $error("advertised current wrong");
   hot_off_a: assert property ((st.therm == TH_RUN) && run && st.sy2[SY_ILIM] && st.sy2[SY_HOT]
      |=> !o_vbus_switch_en ##1 o_flag_oe[FLG_FAULT] || !run)
      else $error("switch not off when hot in limit");
   cool_hold_a: assert property ((st.therm == TH_COOL) && !st.sy2[SY_COOL] |=> st.therm == TH_COOL)
      else $error("restart before cooling");
   restart_a: assert property ((st.therm == TH_COOL) && st.sy2[SY_COOL] |=> st.therm == TH_RUN)
      else $error("no restart after cooling");
   disable_off_a: assert property (!run |=> (o_flag_oe == '0) && !o_vbus_switch_en
      && !o_vconn_cc1_en && !o_vconn_cc2_en)
      else $error("disabled device still active");
   // accessories stay latched while their watched line keeps its termination
   audio_hold_a: assert property (run && deb[FLG_AUDIO] && (cls2 == CC_RA) |=> deb[FLG_AUDIO])
      else $error("audio flag dropped while cc2 still ra");
   debug_hold_a: assert property (run && deb[FLG_DEBUG] && (cls1 == CC_RD) |=> deb[FLG_DEBUG])
      else $error("debug flag dropped while cc1 still rd");
   flip_needs_sink_a: assert property (o_flag_oe[FLG_FLIP] |-> o_flag_oe[FLG_SINK])
      else $error("flip flag without sink flag");
endmodule

// ===== hdl/tsc_deglitch.sv
// asymmetric deglitch filter for one attach flag
`timescale 1ns/100ps
module tsc_deglitch
   import tsc_pkg::*;
#(
   parameter logic [CNT_W-1:0] SET_TICKS = FLAG_SET_TICKS,
   parameter logic [CNT_W-1:0] CLR_TICKS = FLAG_CLR_TICKS
) (
   input  wire logic i_ref_clk,   // reference clock
   input  wire logic i_reset_n,   // synchronous reset
   input  wire logic i_tick,      // time base enable
   input  wire logic i_clear,     // force released, counter idle
   input  wire logic i_raw,       // undeglitched condition
   output logic      o_level      // deglitched condition
);
   // filter state
   typedef struct packed {
      logic             level;    // filtered level
      logic [CNT_W-1:0] cnt;      // ticks the raw level has differed
   } tsc_deg_t;

   tsc_deg_t st;
   tsc_deg_t next_st;

   assign o_level = st.level;

   // count ticks of a stable difference, flip after the set or clear time
   always_comb begin
      next_st = st;
      if (i_clear) begin
         next_st = '0;
      end else if (i_raw == st.level) begin
         next_st.cnt = '0;
      end else if (i_tick) begin
         if (st.cnt + 1'b1 >= (st.level ? CLR_TICKS : SET_TICKS)) begin
            next_st.level = i_raw;
            next_st.cnt   = '0;
         end else begin
            next_st.cnt = st.cnt + 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge i_ref_clk) begin
      if (!i_reset_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_reset_n);

   set_wait_a: assert property ($rose(st.level) |-> $past(st.cnt) == SET_TICKS - 1'b1)
      else $error("flag asserted before its hold time");
   clr_wait_a: assert property ($fell(st.level) && !$past(i_clear) |-> $past(st.cnt) == CLR_TICKS - 1'b1)
      else $error("flag released before its release time");
endmodule

// ===== hdl/tsc_pkg.sv
// shared constants and types for the type-c source attach control block
package tsc_pkg;
   // clock and deglitch time base
   localparam int CLK_MHZ         = 50;                   // reference clock rate
   localparam int TICK_US         = 100;                  // deglitch tick period
   localparam int TICK_CYCLES_DEF = TICK_US * CLK_MHZ;    // cycles per tick
   localparam int TICK_W          = 16;                   // tick counter width
   // deglitch times
   localparam int T_DEGR_US       = 150000;               // flag assert time
   localparam int T_DEGF_US       = 12500;                // flag release time
   localparam int T_CS_US         = 8200;                 // load-sense both ways
   localparam int CNT_W           = 11;                   // deglitch counter width
   localparam logic [CNT_W-1:0] FLAG_SET_TICKS = CNT_W'((T_DEGR_US + TICK_US - 1) / TICK_US);
   localparam logic [CNT_W-1:0] FLAG_CLR_TICKS = CNT_W'(T_DEGF_US / TICK_US);
   localparam logic [CNT_W-1:0] CS_SET_TICKS   = CNT_W'((T_CS_US + TICK_US - 1) / TICK_US);
   localparam logic [CNT_W-1:0] CS_CLR_TICKS   = CNT_W'(T_CS_US / TICK_US);
   // flag positions (open-drain pins), first five are deglitched
   localparam int FLG_FLIP  = 0;                          // plug_flip_n
   localparam int FLG_SINK  = 1;                          // sink_attached_n
   localparam int FLG_AUDIO = 2;                          // audio accessory
   localparam int FLG_DEBUG = 3;                          // debug accessory
   localparam int FLG_CS    = 4;                          // cable compensation
   localparam int FLG_FAULT = 5;                          // thermal fault
   localparam int N_DEB     = 5;
   localparam int N_FLAG    = 6;
   // synchronised pin positions
   localparam int SY_CC1_OPEN = 0;                        // cc1 below open level
   localparam int SY_CC1_RA   = 1;                        // cc1 below ra level
   localparam int SY_CC2_OPEN = 2;
   localparam int SY_CC2_RA   = 3;
   localparam int SY_EN       = 4;
   localparam int SY_SEL_LVL  = 5;
   localparam int SY_SEL_AMP  = 6;
   localparam int SY_ILIM     = 7;
   localparam int SY_HOT      = 8;
   localparam int SY_COOL     = 9;
   localparam int SY_CS       = 10;
   localparam int SY_PIN      = 11;
   localparam int N_SY        = 17;
   // apb register map
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL     = 8'h00;
   localparam logic [ADDR_W-1:0] REG_STATUS   = 8'h04;
   localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 8'h08;
   localparam logic [ADDR_W-1:0] REG_IRQ_MASK = 8'h0C;
   localparam logic [ADDR_W-1:0] REG_PINS     = 8'h10;
   localparam logic CTRL_EN_RST = 1'b1;                   // software enable after reset
   // interrupt status bits
   localparam int IRQ_ATTACH = 0;
   localparam int IRQ_DETACH = 1;
   localparam int IRQ_ACCESS = 2;
   localparam int IRQ_THERM  = 3;
   localparam int N_IRQ      = 4;
   localparam logic [N_IRQ-1:0] IRQ_MASK_RST = 4'h0;
   // advertised current codes
   localparam logic [1:0] ADV_DEFAULT = 2'h0;
   localparam logic [1:0] ADV_1A5     = 2'h1;
   localparam logic [1:0] ADV_3A      = 2'h2;
   // cc line termination class
   typedef enum logic [1:0] {CC_OPEN, CC_RD, CC_RA} tsc_cc_t;
   // overtemperature cycling state
   typedef enum logic {TH_RUN, TH_COOL} tsc_therm_t;
endpackage

// ===== test/tb_top.sv
// self-checking bench for the type-c source attach control block
`timescale 1ns/100ps
module tb_top;
   import tsc_pkg::*;
   logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, en = 1;
   logic lvl = 0, amp = 0, ilim = 0, hot = 0, cool = 0, cs = 0, pready, pslverr;
   logic b1o, b1r, b2o, b2r, vbus, v1, v2, irq;
   logic [7:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [5:0] fout, foe;
   logic [1:0] adv;
   logic err;
   tsc_cc_t t1 = CC_OPEN, t2 = CC_OPEN;  // far-end terminations
   int bad_count = 0, check_count = 0;
   tsc_cc_far_end i_far1 (.i_term(t1), .o_below_open(b1o), .o_below_ra(b1r));
   tsc_cc_far_end i_far2 (.i_term(t2), .o_below_open(b2o), .o_below_ra(b2r));
   tsc_attach_ctrl #(.TICK_CYCLES(2)) i_tsc_attach_ctrl (.i_ref_clk(clk), .i_reset_n(rst_n), .i_psel(psel),
      .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .i_enable(en), .i_cc1_below_open(b1o), .i_cc1_below_ra(b1r),
      .i_cc2_below_open(b2o), .i_cc2_below_ra(b2r), .i_charge_select_hi_level(lvl),
      .i_charge_select_high_amp(amp), .i_in_current_limit(ilim), .i_over_temp(hot), .i_temp_cooled(cool),
      .i_load_above_cs(cs), .i_flag_pin(~foe), .o_flag_out(fout), .o_flag_oe(foe), .o_vbus_switch_en(vbus),
      .o_vconn_cc1_en(v1), .o_vconn_cc2_en(v2), .o_adv_level(adv), .o_irq(irq));
   // 50 mhz clock
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk);
      penable <= 1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata; err = pslverr;
      psel <= 0; penable <= 0;
      @(posedge clk);
   endtask
   task automatic t_regs;
      apb(0, REG_CTRL, 0);     chk("ctrl", rd, 32'h1);
      apb(0, REG_IRQ_MASK, 0); chk("mask", rd, 32'h0);
      apb(0, 8'h14, 0);        chk("unmapped", {rd[30:0], err}, 32'h1);
   endtask
   // attach table: terminations and expected {vconn2, vconn1, vbus, flags}
   task automatic t_attach;
      tsc_cc_t c1[10] = '{CC_OPEN, CC_RD, CC_OPEN, CC_RD, CC_RA, CC_RD, CC_RD, CC_RA, CC_OPEN, CC_OPEN};
      tsc_cc_t c2[10] = '{CC_RA, CC_OPEN, CC_RD, CC_RA, CC_RD, CC_RD, CC_OPEN, CC_RA, CC_RA, CC_OPEN};
      logic [6:0] ex[10] = '{7'h00, 7'h12, 7'h13, 7'h52, 7'h33, 7'h08, 7'h08, 7'h04, 7'h04, 7'h00};
      // rows 6 and 8 keep the watched line, so the accessory flag must hold
      for (int k = 0; k < 10; k++) begin
         t1 <= c1[k]; t2 <= c2[k];
         cyc(3400);
         chk("attach", {v2, v1, vbus, foe[3:0]}, ex[k]);
         chk("od_data", fout, 0);
      end
      t1 <= CC_RD;
      cyc(3400);
   endtask
   task automatic t_adv_cs;
      cs <= 1;
      cyc(200);
      for (int k = 0; k < 4; k++) begin
         {lvl, amp} <= k[1:0];
         cyc(120);
         chk("adv", adv, k[1] ? (k[0] ? ADV_3A : ADV_1A5) : ADV_DEFAULT);
         chk("cs_flag", foe[FLG_CS], 1);
      end
      cs <= 0;
   endtask
   task automatic t_irq;
      apb(1, REG_IRQ_MASK, 32'h1); cyc(2); chk("irq_on", irq, 1);
      apb(1, REG_IRQ_STAT, 32'hF); cyc(2); chk("irq_off", irq, 0);
      apb(0, REG_IRQ_STAT, 0);     chk("stat_clr", rd, 0);
   endtask
   task automatic t_therm;
      ilim <= 1; hot <= 1; cyc(6);
      chk("hot_off", {vbus, foe[FLG_FAULT]}, 2'b01);
      apb(0, REG_IRQ_STAT, 0); chk("therm_irq", rd[IRQ_THERM], 1);
      hot <= 0; cool <= 1; cyc(6);
      chk("restart", vbus, 1);
      ilim <= 0; cool <= 0;
   endtask
   task automatic t_enable;
      en <= 0; cyc(6);
      chk("disabled", {v2, v1, vbus, foe}, 0);
   endtask
   task automatic test_done;
      if (bad_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      cyc(2); rst_n <= 1; cyc(1);
      t_regs; t_attach; t_adv_cs; t_irq; t_therm; t_enable;
      test_done;
   end
   // watchdog against a hung handshake
   initial begin
      cyc(45000); bad_count++; test_done;
   end
endmodule

// ===== test/tsc_cc_far_end.sv
// far-end termination model: turns a termination class into cc comparator levels
`timescale 1ns/100ps
module tsc_cc_far_end
   import tsc_pkg::*;
(
   input  wire tsc_cc_t i_term,        // termination shown on this line
   output logic         o_below_open,  // line pulled under the open level
   output logic         o_below_ra     // line pulled under the ra boundary
);
   // any pulldown drags the line low; a sink shows rd on one contact
   assign o_below_open = (i_term != CC_OPEN);
   // only ra pulls under the rd/ra boundary
   assign o_below_ra = (i_term == CC_RA);
endmodule
